// ### hw/paged_mmu_descriptor_check.sv
// Contract
// R1: three banks of page registers, selected by current processor mode.
// R2: each bank has instruction and data groups; instruction group for fetch-type references.
// R3: other references use data group unless data space disabled, then instruction group.
// R4: eight base/descriptor pairs per group, chosen by top three address bits.
// R5: base register holds 12-bit physical block number; bits 15-12 reserved.
// R6: descriptor bits 2-0 are access key deciding permit, abort or trap.
// R7: aborted reference not completed; trap deferred until instruction finishes.
// R8: any store or modify counts as write.
// R9: key 000 non-resident aborts all accesses.
// R10: key 001 aborts writes, allows reads with trap.
// R11: key 010 aborts writes, allows reads silently.
// R12: keys 011 and 111 reserved, abort all accesses.
// R13: key 100 permits reads and writes, trap after each.
// R14: key 101 reads silent, writes permitted with trap.
// R15: key 110 permits everything without trap or abort.
// R16: accessed flag bit 7 set when access meets key trap condition.
// R17: written flag bit 6 set when page written after last load.
// R18: writing base or descriptor clears both accessed and written flags.
// R19: descriptor bit 3 selects growth direction, 1 means downward.
// R20: bits 14-8 hold extent: length-1 upward, 128-length downward.
// R21: length error if index above extent upward, below extent downward.
// R22: descriptor bits 15, 5, 4 read zero.
// R23: virtual address splits into page select, block index, block offset.
// R24: physical block = base + index, offset appended, 18-bit address.
`timescale 1ns/1ps
`default_nettype none

module paged_mmu_descriptor_check
(
  // clock and reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_NRST,
  // reference from the core
  input  wire logic        I_REQ,
  input  wire logic [15:0] I_VADDR,
  input  wire logic [1:0]  I_MODE,
  input  wire logic        I_ISPACE,
  input  wire logic        I_WRITE,
  input  wire logic        I_DSPACE_OFF,
  input  wire logic        I_INSTR_DONE,
  // register load and read port
  input  wire logic        I_REG_WR,
  input  wire logic [5:0]  I_REG_IDX,
  input  wire logic        I_REG_DESC,
  input  wire logic [15:0] I_REG_WDATA,
  output logic      [15:0] O_REG_RDATA,
  // reference outcome
  output logic             O_DONE,
  output logic      [17:0] O_PADDR,
  output logic             O_ABORT,
  output logic             O_ABORT_ABSENT,
  output logic             O_ABORT_LENGTH,
  output logic             O_ABORT_RDONLY,
  output logic             O_TRAP
);

  // ****************************************
  // register store
  // ****************************************
  // index = bank(2) * 16 + dspace * 8 + page; mode 3 uses bank 2, mode 2 has no bank
  logic [15:0] base_mem [page_check_pkg::N_REG];
  logic [15:0] desc_mem [page_check_pkg::N_REG];

  function automatic logic [5:0] bank_index(input logic [1:0] mode, input logic dsp, input logic [2:0] pg);
    logic [1:0] b;
    b = (mode == page_check_pkg::MODE_LEAST) ? 2'h2 : mode;   // R1
    return {b, dsp, pg};                                      // R2 R4
  endfunction

  // ****************************************
  // reference decode
  // ****************************************
  logic [2:0]  page_select;
  logic [6:0]  virtual_block_index;
  logic [5:0]  offset_in_block;
  logic        use_dspace;
  logic [5:0]  ref_idx;
  logic [15:0] page_descriptor_reg;
  logic [15:0] page_base_reg;
  logic [2:0]  access_key;
  logic        growth_direction;
  logic [6:0]  page_extent;
  logic        bad_mode;
  logic        absent;
  logic        length_err;
  logic        rdonly_err;
  logic        trap_cond;
  logic        abort_now;
  logic [11:0] phys_block;

  always_comb
  begin
    page_select         = I_VADDR[page_check_pkg::SEL_MSB:page_check_pkg::SEL_LSB]; // R23
    virtual_block_index = I_VADDR[page_check_pkg::BLK_MSB:page_check_pkg::BLK_LSB];
    offset_in_block     = I_VADDR[page_check_pkg::OFS_MSB:page_check_pkg::OFS_LSB];
    use_dspace          = !I_ISPACE && !I_DSPACE_OFF;                                 // R3
    ref_idx             = bank_index(I_MODE, use_dspace, page_select);
    bad_mode            = (I_MODE == 2'h2);
    page_descriptor_reg = bad_mode ? 16'h0000 : desc_mem[ref_idx];
    page_base_reg       = bad_mode ? 16'h0000 : base_mem[ref_idx];
    access_key          = page_descriptor_reg[page_check_pkg::KEY_MSB:page_check_pkg::KEY_LSB]; // R6
    growth_direction    = page_descriptor_reg[page_check_pkg::DIR_BIT];                         // R19
    page_extent         = page_descriptor_reg[page_check_pkg::EXT_MSB:page_check_pkg::EXT_LSB]; // R20
    length_err          = growth_direction ? (virtual_block_index < page_extent)
                                           : (virtual_block_index > page_extent);              // R21
    absent              = 1'b0;
    rdonly_err          = 1'b0;
    trap_cond           = 1'b0;
    case (access_key)
      page_check_pkg::KEY_ABSENT:   absent = 1'b1;                                // R9
      page_check_pkg::KEY_RO_TRAP:
      begin
        rdonly_err = I_WRITE;                                                      // R10 R8
        trap_cond  = !I_WRITE;
      end
      page_check_pkg::KEY_RO:       rdonly_err = I_WRITE;                          // R11
      page_check_pkg::KEY_RSV3,
      page_check_pkg::KEY_RSV7:     absent = 1'b1;                                // R12
      page_check_pkg::KEY_RW_TRAP:  trap_cond = 1'b1;                             // R13
      page_check_pkg::KEY_RW_WTRAP: trap_cond = I_WRITE;                          // R14
      page_check_pkg::KEY_RW:       trap_cond = 1'b0;                             // R15
      default:                      absent = 1'b1;
    endcase
    absent              = absent || bad_mode;
    abort_now           = absent || length_err || rdonly_err;
    phys_block          = page_base_reg[page_check_pkg::BASE_W-1:0] + {5'h00, virtual_block_index}; // R24
  end

  // ****************************************
  // register load and flag update
  // ****************************************
  logic        ref_fire;

  assign ref_fire = I_REQ && !abort_now;   // R7

  // a load and a flag set on the same pair in one cycle: the load wins,
  // since it starts a fresh page and must leave both flags clear
  always_ff @(posedge I_CORE_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      for (int k = 0; k < page_check_pkg::N_REG; k++)
      begin
        base_mem[k] <= page_check_pkg::REG_RESET;
        desc_mem[k] <= page_check_pkg::REG_RESET;
      end
    end
    else
    begin
      if (ref_fire && trap_cond)
        desc_mem[ref_idx][page_check_pkg::ACCESSED_BIT] <= 1'b1;   // R16
      if (ref_fire && I_WRITE)
        desc_mem[ref_idx][page_check_pkg::WRITTEN_BIT] <= 1'b1;    // R17
      if (I_REG_WR && (I_REG_IDX < 6'(page_check_pkg::N_REG)))
      begin
        if (I_REG_DESC)
          desc_mem[I_REG_IDX] <= I_REG_WDATA & page_check_pkg::DESC_WMASK;  // R18 R22
        else
        begin
          base_mem[I_REG_IDX] <= I_REG_WDATA & page_check_pkg::BASE_WMASK;  // R5
          desc_mem[I_REG_IDX][page_check_pkg::ACCESSED_BIT] <= 1'b0;        // R18
          desc_mem[I_REG_IDX][page_check_pkg::WRITTEN_BIT]  <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // outcome registers
  // ****************************************
  logic        trap_pend;
  logic        next_trap_pend;
  logic        next_done;
  logic [17:0] next_paddr;
  logic        next_abort;
  logic        next_abs;
  logic        next_len;
  logic        next_ro;
  logic        next_trap;
  logic [15:0] next_rdata;

  always_comb
  begin
    next_done      = ref_fire;
    next_paddr     = ref_fire ? {phys_block, offset_in_block} : O_PADDR;
    next_abort     = I_REQ && abort_now;                     // R7
    next_abs       = I_REQ && absent;
    next_len       = I_REQ && length_err;
    next_ro        = I_REQ && rdonly_err;
    next_trap_pend = trap_pend || (ref_fire && trap_cond);
    next_trap      = 1'b0;
    if (I_INSTR_DONE)
    begin
      next_trap      = next_trap_pend;                       // R7
      next_trap_pend = 1'b0;
    end
    next_rdata     = 16'h0000;
    if (I_REG_IDX < 6'(page_check_pkg::N_REG))
      next_rdata   = I_REG_DESC ? desc_mem[I_REG_IDX] : base_mem[I_REG_IDX];
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      trap_pend      <= 1'b0;
      O_DONE         <= 1'b0;
      O_PADDR        <= 18'h00000;
      O_ABORT        <= 1'b0;
      O_ABORT_ABSENT <= 1'b0;
      O_ABORT_LENGTH <= 1'b0;
      O_ABORT_RDONLY <= 1'b0;
      O_TRAP         <= 1'b0;
      O_REG_RDATA    <= 16'h0000;
    end
    else
    begin
      trap_pend      <= next_trap_pend;
      O_DONE         <= next_done;
      O_PADDR        <= next_paddr;
      O_ABORT        <= next_abort;
      O_ABORT_ABSENT <= next_abs;
      O_ABORT_LENGTH <= next_len;
      O_ABORT_RDONLY <= next_ro;
      O_TRAP         <= next_trap;
      O_REG_RDATA    <= next_rdata;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  absent_abort_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R9
    I_REQ && !bad_mode && access_key == page_check_pkg::KEY_ABSENT |=> O_ABORT && O_ABORT_ABSENT && !O_DONE)
    else $error("non-resident page not aborted");
  ro_write_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R10
    I_REQ && I_WRITE && !bad_mode && access_key == page_check_pkg::KEY_RO_TRAP |=> O_ABORT_RDONLY && !O_DONE)
    else $error("write to read-only page not aborted");
  ro_silent_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R11
    I_REQ && !I_WRITE && !bad_mode && access_key == page_check_pkg::KEY_RO && !length_err |=> O_DONE && !O_ABORT)
    else $error("read of read-only page not completed");
  rsv_abort_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R12
    I_REQ && (access_key == page_check_pkg::KEY_RSV3 || access_key == page_check_pkg::KEY_RSV7) |=> O_ABORT_ABSENT)
    else $error("reserved key not aborted");
  rw_free_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R15
    I_REQ && !bad_mode && access_key == page_check_pkg::KEY_RW && !length_err && !trap_pend && !I_INSTR_DONE
    |=> O_DONE && !O_ABORT && !trap_pend)
    else $error("free page raised trap or abort");
  trap_defer_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R7
    O_TRAP |-> $past(I_INSTR_DONE))
    else $error("trap not deferred to instruction end");
  len_up_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R21
    I_REQ && !growth_direction && virtual_block_index > page_extent |=> O_ABORT_LENGTH)
    else $error("upward length error missed");
  paddr_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R24
    ref_fire |=> O_PADDR == {$past(page_base_reg[11:0]) + {5'h00, $past(I_VADDR[12:6])}, $past(I_VADDR[5:0])})
    else $error("physical address wrong");
  flag_clear_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R18
    I_REG_WR && I_REG_IDX < 6'(page_check_pkg::N_REG) |=> desc_mem[$past(I_REG_IDX)][7:6] == 2'h0)
    else $error("flags not cleared on load");
  mode_abort_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R1
    I_REQ && bad_mode |=> O_ABORT && O_ABORT_ABSENT && !O_DONE)
    else $error("illegal mode not aborted");
  ispace_group_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R2
    I_REQ && I_ISPACE |-> !ref_idx[3])
    else $error("instruction reference used data group");
  dspace_group_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R3
    I_REQ && !I_ISPACE |-> ref_idx[3] == !I_DSPACE_OFF)
    else $error("data reference used wrong group");
  ro_trap_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R10
    I_REQ && !I_WRITE && !bad_mode && access_key == page_check_pkg::KEY_RO_TRAP && !length_err && !I_INSTR_DONE
    |=> O_DONE && trap_pend)
    else $error("read of trapping read-only page did not trap");
  rw_trap_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R13
    I_REQ && !bad_mode && access_key == page_check_pkg::KEY_RW_TRAP && !length_err && !I_INSTR_DONE
    |=> O_DONE && trap_pend)
    else $error("trapping read/write page did not trap");
  write_trap_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R14
    I_REQ && !bad_mode && access_key == page_check_pkg::KEY_RW_WTRAP && !length_err && !trap_pend && !I_INSTR_DONE
    |=> O_DONE && trap_pend == $past(I_WRITE))
    else $error("write-trap page trapped wrongly");
  len_down_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R21
    I_REQ && growth_direction && virtual_block_index < page_extent
    |=> O_ABORT_LENGTH && !O_DONE)
    else $error("downward length error missed");
  acc_flag_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R16
    ref_fire && trap_cond && !I_REG_WR
    |=> desc_mem[$past(ref_idx)][page_check_pkg::ACCESSED_BIT])
    else $error("accessed flag not set");
  wr_flag_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R17
    ref_fire && I_WRITE && !I_REG_WR
    |=> desc_mem[$past(ref_idx)][page_check_pkg::WRITTEN_BIT])
    else $error("written flag not set");
  desc_rsv_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R22
    I_REG_DESC |=> (O_REG_RDATA & 16'h8030) == 16'h0000)
    else $error("reserved descriptor bits not zero");
  base_rsv_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R5
    !I_REG_DESC |=> O_REG_RDATA[15:12] == 4'h0)
    else $error("reserved base bits not zero");
  trap_release_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R7
    I_INSTR_DONE && (trap_pend || (ref_fire && trap_cond)) |=> O_TRAP)
    else $error("pending trap not released at instruction end");
  paddr_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // R24
    !ref_fire |=> $stable(O_PADDR))
    else $error("physical address changed without completion");

endmodule // paged_mmu_descriptor_check

`default_nettype wire

// ### hw/page_check_pkg.sv
`default_nettype none

package page_check_pkg;

  // ****************************************
  // address fields
  // ****************************************
  localparam int VA_W          = 16;
  localparam int PA_W          = 18;
  localparam int SEL_MSB       = 15;
  localparam int SEL_LSB       = 13;
  localparam int BLK_MSB       = 12;
  localparam int BLK_LSB       = 6;
  localparam int OFS_MSB       = 5;
  localparam int OFS_LSB       = 0;
  localparam int BASE_W        = 12;

  // ****************************************
  // descriptor fields
  // ****************************************
  localparam int KEY_MSB       = 2;
  localparam int KEY_LSB       = 0;
  localparam int DIR_BIT       = 3;
  localparam int WRITTEN_BIT   = 6;
  localparam int ACCESSED_BIT  = 7;
  localparam int EXT_MSB       = 14;
  localparam int EXT_LSB       = 8;

  // writable descriptor bits: extent, direction, key
  localparam logic [15:0] DESC_WMASK   = 16'h7f0f;
  localparam logic [15:0] BASE_WMASK   = 16'h0fff;
  localparam logic [15:0] REG_RESET    = 16'h0000;

  // ****************************************
  // register selection
  // ****************************************
  localparam int N_MODE        = 3;
  localparam int N_PAGE        = 8;
  localparam int N_REG         = 48;
  localparam logic [1:0] MODE_MOST   = 2'h0;
  localparam logic [1:0] MODE_MIDDLE = 2'h1;
  localparam logic [1:0] MODE_LEAST  = 2'h3;

  // ****************************************
  // access keys
  // ****************************************
  localparam logic [2:0] KEY_ABSENT    = 3'h0;
  localparam logic [2:0] KEY_RO_TRAP   = 3'h1;
  localparam logic [2:0] KEY_RO        = 3'h2;
  localparam logic [2:0] KEY_RSV3      = 3'h3;
  localparam logic [2:0] KEY_RW_TRAP   = 3'h4;
  localparam logic [2:0] KEY_RW_WTRAP  = 3'h5;
  localparam logic [2:0] KEY_RW        = 3'h6;
  localparam logic [2:0] KEY_RSV7      = 3'h7;

endpackage

`default_nettype wire

// ### testbench/core_ref_model.sv
`timescale 1ns/1ps
`default_nettype none

module core_ref_model
(
  // clock
  input  wire logic        i_clk,
  // references
  output logic             o_req,
  output logic      [15:0] o_vaddr,
  output logic      [1:0]  o_mode,
  output logic             o_ispace,
  output logic             o_write,
  output logic             o_dsoff,
  output logic             o_idone,
  // register port
  output logic             o_reg_wr,
  output logic      [5:0]  o_reg_idx,
  output logic             o_reg_desc,
  output logic      [15:0] o_reg_wdata
);
  // ****************************************
  // bus cycles of the core
  // ****************************************
  initial
  begin
    {o_req, o_vaddr, o_mode, o_ispace, o_write, o_dsoff, o_idone} = '0;
    {o_reg_wr, o_reg_idx, o_reg_desc, o_reg_wdata} = '0;
  end

  // address is inverted once released so a stale value never looks valid
  task automatic ref_go(input logic [15:0] va, input logic [1:0] md, input logic is, wr, dso);
    @(posedge i_clk);
    {o_req, o_vaddr, o_mode, o_ispace, o_write, o_dsoff} <= {1'b1, va, md, is, wr, dso};
    @(posedge i_clk);
    {o_req, o_vaddr} <= {1'b0, ~va};
  endtask

  task automatic reg_go(input logic [5:0] x, input logic dsc, wr, input logic [15:0] d);
    @(posedge i_clk);
    {o_reg_wr, o_reg_idx, o_reg_desc, o_reg_wdata} <= {wr, x, dsc, d};
    @(posedge i_clk);
    {o_reg_wr, o_reg_wdata} <= {1'b0, ~d};
  endtask

  task automatic instr_end;
    @(posedge i_clk);
    o_idone <= 1'b1;
    @(posedge i_clk);
    o_idone <= 1'b0;
  endtask
endmodule // core_ref_model

`default_nettype wire

// ### testbench/paged_mmu_descriptor_check_test.sv
`timescale 1ns/1ps
`default_nettype none

module paged_mmu_descriptor_check_test;
  logic        clk, nrst, req, isp, wr, dso, idn, rwr, rdsc, done, ab, aa, al, ar, trp, pend;
  logic [15:0] va, wd, rd;
  logic [1:0]  md;
  logic [5:0]  ridx;
  logic [17:0] pa, pexp;
  int          fail_count, compares, seed, k, r, bs[64], ds[64], af[64], wf[64];

  paged_mmu_descriptor_check paged_mmu_descriptor_check_i (.I_CORE_CLK(clk), .I_NRST(nrst),
    .I_REQ(req), .I_VADDR(va), .I_MODE(md), .I_ISPACE(isp), .I_WRITE(wr), .I_DSPACE_OFF(dso),
    .I_INSTR_DONE(idn), .I_REG_WR(rwr), .I_REG_IDX(ridx), .I_REG_DESC(rdsc), .I_REG_WDATA(wd),
    .O_REG_RDATA(rd), .O_DONE(done), .O_PADDR(pa), .O_ABORT(ab), .O_ABORT_ABSENT(aa),
    .O_ABORT_LENGTH(al), .O_ABORT_RDONLY(ar), .O_TRAP(trp));
  core_ref_model core_ref_model_i (.i_clk(clk), .o_req(req), .o_vaddr(va), .o_mode(md),
    .o_ispace(isp), .o_write(wr), .o_dsoff(dso), .o_idone(idn), .o_reg_wr(rwr),
    .o_reg_idx(ridx), .o_reg_desc(rdsc), .o_reg_wdata(wd));

  // ****************************************
  // compares and reference model
  // ****************************************
  task automatic note(input bit ok, input string m);
    compares++;
    if (!ok)
    begin
      fail_count++;
      $display("Error %0t %s mismatch", $time, m);
    end
  endtask

  task automatic chk_ref(input logic [22:0] g, e); note(g === e, "reference"); endtask
  task automatic chk_reg(input logic [15:0] g, e); note(g === e, "register"); endtask
  task automatic chk_trap(input logic g, e); note(g === e, "trap"); endtask

  task automatic reg_wr(input int x, input logic dsc, input logic [15:0] d);
    core_ref_model_i.reg_go(6'(x), dsc, 1'b1, d);
    if (x < 48)
    begin
      if (dsc) ds[x] = d & page_check_pkg::DESC_WMASK;
      else bs[x] = d & page_check_pkg::BASE_WMASK;
      af[x] = 0;
      wf[x] = 0;
    end
  endtask

  task automatic read_all;
    for (int x = 0; x < 96; x++)
    begin
      core_ref_model_i.reg_go(6'(x / 2), x[0], 1'b0, 16'h0000);
      @(negedge clk);
      chk_reg(rd, 16'(x[0] ? ds[x / 2] | af[x / 2] << 7 | wf[x / 2] << 6 : bs[x / 2]));
    end
  endtask

  task automatic do_ref(input logic [15:0] v, input logic [1:0] m, input logic i, w, d);
    int x, key, blk, dsc;
    logic abs, lg, ro, tr, abt;
    x = (m == 2'h3 ? 2 : int'(m)) * 16 + ((i || d) ? 0 : 8) + int'(v[15:13]);
    dsc = (m == 2'h2) ? 0 : ds[x];
    key = dsc & 7;
    blk = int'(v[12:6]);
    lg = dsc[3] ? blk < ((dsc >> 8) & 127) : blk > ((dsc >> 8) & 127);
    abs = m == 2'h2 || key inside {0, 3, 7};
    ro = w && key inside {1, 2};
    tr = w ? key inside {4, 5} : key inside {1, 4};
    abt = abs | lg | ro;
    if (!abt) pexp = {bs[x][11:0] + 12'(blk), v[5:0]};
    core_ref_model_i.ref_go(v, m, i, w, d);
    @(negedge clk);
    chk_ref({done, ab, aa, al, ar, pa}, {!abt, abt, abs, lg, ro, pexp});
    if (!abt)
    begin
      pend |= tr;
      af[x] |= int'(tr);
      wf[x] |= int'(w);
    end
  endtask

  task automatic instr_end;
    core_ref_model_i.instr_end;
    @(negedge clk);
    chk_trap(trp, pend);
    pend = 1'b0;
  endtask

  task automatic finish_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************
  // stimulus
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    #400000;
    fail_count++;
    $display("Error %0t run did not end", $time);
    finish_test;
  end

  initial
  begin
    {seed, nrst, fail_count, compares, pend, pexp} = {97548, 1'b0, 0, 0, 1'b0, 18'h0};
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    do_ref(16'h0000, 2'h2, 1'b0, 1'b0, 1'b0);
    read_all;
    $display("test reset done");
    for (k = 0; k < 96; k++) reg_wr(k / 2, k[0], 16'($random(seed)));
    reg_wr(63, 1'b1, 16'hffff);
    read_all;
    $display("test register load done");
    for (k = 0; k < 64; k++)
    begin
      reg_wr(8, 1'b1, {1'b0, 7'h05, 4'h0, k[4], k[2:0]});
      do_ref({3'h0, 7'(k[4] ? 4 + k[5] : 5 + k[5]), 6'(k)}, 2'h0, 1'b0, k[3], 1'b0);
      if (k[5]) instr_end;
    end
    read_all;
    $display("test keys and lengths done");
    for (k = 0; k < 400; k++)
    begin
      r = $random(seed);
      if (r[1:0] == 2'h0) reg_wr(int'(r[7:2]) % 48, r[8], 16'($random(seed)));
      else if (r[1:0] == 2'h1) instr_end;
      else do_ref(16'($random(seed)), r[3:2], r[4], r[5], r[6]);
    end
    read_all;
    $display("test random traffic done");
    finish_test;
  end
endmodule // paged_mmu_descriptor_check_test

`default_nettype wire
